/* File: logic/hssi_map.svh */
// Purpose: Named constants of the host serial slave interfaces.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef HSSI_MAP_SVH
`define HSSI_MAP_SVH

// I2C slave address after reset
`define HSSI_I2C_DEF_ADDR   7'h60
// Index of the last bit of an eight-bit character
`define HSSI_LAST_BIT       3'h7
// Synchroniser reset levels, order {mosi, ssel_n, sclk}; select idles high
`define HSSI_SPI_SYNC_RST   3'h2
// I2C synchroniser reset levels, order {sda, scl}; both lines idle high
`define HSSI_I2C_SYNC_RST   2'h3
// Fastest I2C bit rate the host may use, in kbit/s
`define HSSI_I2C_MAX_KBPS   400

`endif

/* File: logic/hssi_pkg.sv */
// Purpose: Types shared by the host serial slave interfaces.
// Assumes: Nothing.
// Notes:   Mode encodings follow the enum order.
package hssi_pkg;

  typedef enum logic [1:0] {
    HSSI_MODE_STREAM,
    HSSI_MODE_TB_SPI,
    HSSI_MODE_TB_I2C,
    HSSI_MODE_OFF
  } hssi_mode_type;

  typedef enum logic [2:0] {
    HSSI_I2C_IDLE,
    HSSI_I2C_ADDR,
    HSSI_I2C_ACK,
    HSSI_I2C_RX,
    HSSI_I2C_TX,
    HSSI_I2C_MACK
  } hssi_i2c_state_type;

endpackage

/* File: logic/hssi_i2c_slave.sv */
// Purpose: I2C slave with 7-bit addressing and clock stretching.
// Assumes: i_clk is far faster than the fastest SCL the host may drive.
// Notes:   Open-drain pins: an enable high pulls the line low.
`timescale 1ns/1ns
`include "hssi_map.svh"

module hssi_i2c_slave
  import hssi_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_enable,
  input  wire logic [6:0] i_addr,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_hold,
  input  wire logic [7:0] i_tx_data,
  output logic            o_scl_oe,
  output logic            o_sda_oe,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid,
  output logic            o_tx_req,
  output logic            o_addr_hit,
  output logic            o_read
);

  hssi_i2c_state_type st_q;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic       last_q;
  logic       match_q;
  logic       read_q;
  logic       scl_oe_q;
  logic       sda_oe_q;
  logic [7:0] rx_data_q;
  logic       rx_valid_q;
  logic       tx_req_q;
  logic       addr_hit_q;

  // Sampling at i_clk leaves wide margin at the fast-mode bit rate
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= `HSSI_I2C_SYNC_RST;
      sync_q <= `HSSI_I2C_SYNC_RST;
      prev_q <= `HSSI_I2C_SYNC_RST;
    end else begin
      meta_q <= {i_sda, i_scl};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire       scl       = sync_q[0];
  wire       sda       = sync_q[1];
  wire       scl_rise  = scl & ~prev_q[0];
  wire       scl_fall  = ~scl & prev_q[0];
  wire       start_det = scl & prev_q[0] & prev_q[1] & ~sda;
  wire       stop_det  = scl & prev_q[0] & ~prev_q[1] & sda;
  wire [7:0] sh_in     = {sh_q[6:0], sda};
  wire       at_last   = (cnt_q == `HSSI_LAST_BIT);
  wire       addr_ok   = (sh_in[7:1] == i_addr);
  // Stretch ends only when the user side lets go of i_hold
  wire       ack_end   = (st_q == HSSI_I2C_ACK) & ~i_hold & (scl_fall | scl_oe_q);
  wire       addr_end  = (st_q == HSSI_I2C_ADDR) & scl_fall & last_q;
  wire       mack_load = (st_q == HSSI_I2C_MACK) & scl_fall & last_q;
  wire       tx_load   = (ack_end & read_q) | mack_load;
  wire       rx_done   = (st_q == HSSI_I2C_RX) & scl_rise & at_last;

  always_ff @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      st_q     <= HSSI_I2C_IDLE;
      cnt_q    <= 3'h0;
      sh_q     <= 8'h00;
      last_q   <= 1'h0;
      match_q  <= 1'h0;
      read_q   <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else if (start_det) begin
      st_q     <= HSSI_I2C_ADDR;
      cnt_q    <= 3'h0;
      last_q   <= 1'h0;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else if (stop_det) begin
      st_q     <= HSSI_I2C_IDLE;
      scl_oe_q <= 1'h0;
      sda_oe_q <= 1'h0;
    end else begin
      case (st_q)
        HSSI_I2C_IDLE: begin
          sda_oe_q <= 1'h0;
        end
        HSSI_I2C_ADDR: begin
          if (scl_rise) begin
            sh_q    <= sh_in;
            cnt_q   <= cnt_q + 3'h1;
            last_q  <= at_last;
            match_q <= addr_ok;
            read_q  <= sda;
          end else if (addr_end) begin
            last_q <= 1'h0;
            if (match_q) begin
              st_q     <= HSSI_I2C_ACK;
              sda_oe_q <= 1'h1;
            end else begin
              st_q <= HSSI_I2C_IDLE;
            end
          end
        end
        HSSI_I2C_ACK: begin
          if (ack_end) begin
            scl_oe_q <= 1'h0;
            cnt_q    <= 3'h0;
            if (read_q) begin
              st_q     <= HSSI_I2C_TX;
              sh_q     <= i_tx_data;
              sda_oe_q <= ~i_tx_data[7];
            end else begin
              st_q     <= HSSI_I2C_RX;
              sda_oe_q <= 1'h0;
            end
          end else if (scl_fall && i_hold) begin
            scl_oe_q <= 1'h1;
          end
        end
        HSSI_I2C_RX: begin
          if (scl_rise) begin
            sh_q   <= sh_in;
            cnt_q  <= cnt_q + 3'h1;
            last_q <= at_last;
          end else if (scl_fall && last_q) begin
            last_q   <= 1'h0;
            st_q     <= HSSI_I2C_ACK;
            sda_oe_q <= 1'h1;
          end
        end
        HSSI_I2C_TX: begin
          if (scl_rise) begin
            cnt_q  <= cnt_q + 3'h1;
            last_q <= at_last;
          end else if (scl_fall) begin
            if (last_q) begin
              last_q   <= 1'h0;
              st_q     <= HSSI_I2C_MACK;
              sda_oe_q <= 1'h0;
            end else begin
              sh_q     <= {sh_q[6:0], 1'h0};
              sda_oe_q <= ~sh_q[6];
            end
          end
        end
        HSSI_I2C_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              st_q <= HSSI_I2C_IDLE;
            end else begin
              last_q <= 1'h1;
            end
          end else if (mack_load) begin
            last_q   <= 1'h0;
            cnt_q    <= 3'h0;
            st_q     <= HSSI_I2C_TX;
            sh_q     <= i_tx_data;
            sda_oe_q <= ~i_tx_data[7];
          end
        end
        default: begin
          st_q <= HSSI_I2C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_data_q  <= 8'h00;
      rx_valid_q <= 1'h0;
      tx_req_q   <= 1'h0;
      addr_hit_q <= 1'h0;
    end else begin
      rx_valid_q <= rx_done;
      tx_req_q   <= tx_load;
      addr_hit_q <= addr_end & match_q;
      if (rx_done) begin
        rx_data_q <= sh_in;
      end
    end
  end

  assign o_scl_oe   = scl_oe_q;
  assign o_sda_oe   = sda_oe_q;
  assign o_rx_data  = rx_data_q;
  assign o_rx_valid = rx_valid_q;
  assign o_tx_req   = tx_req_q;
  assign o_addr_hit = addr_hit_q;
  assign o_read     = read_q;

endmodule

/* File: logic/hssi_top.sv */
// Purpose: Host serial slave port: SPI slave and I2C slave, at most one active per mode.
// Assumes: Host SPI clock is much slower than i_clk; all pins are asynchronous.
// Notes:   Tri-state pins come out as value plus enable; open-drain pins as an enable only.
`timescale 1ns/1ns
`include "hssi_map.svh"

// Overview of operation
// - SPI slave works only in stream-cipher or toolbox-over-SPI mode.
// - SPI is four-wire full duplex; host drives select and clock.
// - Characters shift least significant bit first in both directions.
// - Mode 0: clock idles low, sample on rise, change on fall.
// - I2C slave works only in toolbox-over-I2C mode.
// - I2C is slave only; host stays at or below fast-mode rate.
// - I2C answers a 7-bit address, 0x60 after reset, configurable.
// - I2C slave may stretch SCL; host waits for release.
// - At most one host interface is in use, chosen by application mode; none in off mode.
// - SPI command set accepted only in stream-cipher mode.
module hssi_top
  import hssi_pkg::*;
#(
  parameter logic [6:0] P_I2C_DEF_ADDR = `HSSI_I2C_DEF_ADDR
)
(
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  input  wire hssi_mode_type i_mode,
  input  wire logic          i_spi_sclk,
  input  wire logic          i_spi_ssel_n,
  input  wire logic          i_spi_mosi,
  output logic               o_spi_miso,
  output logic               o_spi_miso_oe,
  input  wire logic [7:0]    i_spi_tx_data,
  output logic               o_spi_tx_load,
  output logic [7:0]         o_spi_rx_data,
  output logic               o_spi_rx_valid,
  output logic               o_spi_cmd_valid,
  output logic               o_spi_active,
  output logic               o_spi_frame_err,
  output logic               o_spi_mode_err,
  input  wire logic [6:0]    i_i2c_addr,
  input  wire logic          i_i2c_addr_wr,
  output logic [6:0]         o_i2c_addr,
  input  wire logic          i_i2c_scl,
  input  wire logic          i_i2c_sda,
  output logic               o_i2c_scl_oe,
  output logic               o_i2c_sda_oe,
  input  wire logic          i_i2c_hold,
  input  wire logic [7:0]    i_i2c_tx_data,
  output logic               o_i2c_tx_req,
  output logic [7:0]         o_i2c_rx_data,
  output logic               o_i2c_rx_valid,
  output logic               o_i2c_addr_hit,
  output logic               o_i2c_read
);

  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic       sclk_prev_q;
  logic       sel_prev_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic       miso_q;
  logic       miso_oe_q;
  logic [7:0] rx_data_q;
  logic       rx_valid_q;
  logic       cmd_valid_q;
  logic       tx_load_q;
  logic       active_q;
  logic       frame_err_q;
  logic       mode_err_q;
  logic [6:0] i2c_addr_q;

  // Mode decode keeps the two ports mutually exclusive
  wire spi_en    = (i_mode == HSSI_MODE_STREAM) | (i_mode == HSSI_MODE_TB_SPI);
  wire i2c_en    = (i_mode == HSSI_MODE_TB_I2C);
  wire stream_md = (i_mode == HSSI_MODE_STREAM);

  // Every pin passes two flops before any logic looks at it
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_meta_q <= `HSSI_SPI_SYNC_RST;
      pin_sync_q <= `HSSI_SPI_SYNC_RST;
    end else begin
      pin_meta_q <= {i_spi_mosi, i_spi_ssel_n, i_spi_sclk};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire sclk_s  = pin_sync_q[0];
  wire ssel_ns = pin_sync_q[1];
  wire mosi_s  = pin_sync_q[2];

  // Host owns select and clock; the port only follows them
  wire sel       = ~ssel_ns & spi_en;
  wire sel_start = sel & ~sel_prev_q;
  wire sel_end   = ~sel & sel_prev_q;
  wire sclk_rise = sel & sclk_s & ~sclk_prev_q;
  wire sclk_fall = sel & ~sclk_s & sclk_prev_q;
  wire byte_done = sclk_rise & (bit_cnt_q == `HSSI_LAST_BIT);

  // New bits enter at the top so bit 0 arrives first
  wire [7:0] rx_byte = {mosi_s, rx_sh_q[7:1]};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sclk_prev_q <= 1'h0;
      sel_prev_q  <= 1'h0;
    end else begin
      sclk_prev_q <= sclk_s;
      sel_prev_q  <= sel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || !sel) begin
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_sh_q <= 8'h00;
    end else if (sclk_rise) begin
      rx_sh_q <= rx_byte;
    end
  end

  // Next character is taken whole at the last rise; its bit 0 leaves on the next fall
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_sh_q <= 8'h00;
      miso_q  <= 1'h0;
    end else if (sel_start) begin
      tx_sh_q <= {1'h0, i_spi_tx_data[7:1]};
      miso_q  <= i_spi_tx_data[0];
    end else if (byte_done) begin
      tx_sh_q <= i_spi_tx_data;
    end else if (sclk_fall) begin
      tx_sh_q <= {1'h0, tx_sh_q[7:1]};
      miso_q  <= tx_sh_q[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      miso_oe_q <= 1'h0;
      active_q  <= 1'h0;
    end else begin
      miso_oe_q <= sel;
      active_q  <= sel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_data_q   <= 8'h00;
      rx_valid_q  <= 1'h0;
      cmd_valid_q <= 1'h0;
      tx_load_q   <= 1'h0;
    end else begin
      rx_valid_q  <= byte_done;
      cmd_valid_q <= byte_done & stream_md;
      tx_load_q   <= sel_start | byte_done;
      if (byte_done) begin
        rx_data_q <= rx_byte;
      end
    end
  end

  // Flag a select dropped mid-character, and a clock not idling low at select
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_err_q <= 1'h0;
      mode_err_q  <= 1'h0;
    end else begin
      frame_err_q <= sel_end & (bit_cnt_q != 3'h0);
      mode_err_q  <= sel_start & sclk_s;
    end
  end

  // Address survives mode changes; only reset restores the default
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      i2c_addr_q <= P_I2C_DEF_ADDR;
    end else if (i_i2c_addr_wr) begin
      i2c_addr_q <= i_i2c_addr;
    end
  end

  hssi_i2c_slave u_i2c (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_enable   (i2c_en),
    .i_addr     (i2c_addr_q),
    .i_scl      (i_i2c_scl),
    .i_sda      (i_i2c_sda),
    .i_hold     (i_i2c_hold),
    .i_tx_data  (i_i2c_tx_data),
    .o_scl_oe   (o_i2c_scl_oe),
    .o_sda_oe   (o_i2c_sda_oe),
    .o_rx_data  (o_i2c_rx_data),
    .o_rx_valid (o_i2c_rx_valid),
    .o_tx_req   (o_i2c_tx_req),
    .o_addr_hit (o_i2c_addr_hit),
    .o_read     (o_i2c_read)
  );

  assign o_spi_miso      = miso_q;
  assign o_spi_miso_oe   = miso_oe_q;
  assign o_spi_tx_load   = tx_load_q;
  assign o_spi_rx_data   = rx_data_q;
  assign o_spi_rx_valid  = rx_valid_q;
  assign o_spi_cmd_valid = cmd_valid_q;
  assign o_spi_active    = active_q;
  assign o_spi_frame_err = frame_err_q;
  assign o_spi_mode_err  = mode_err_q;
  assign o_i2c_addr      = i2c_addr_q;

endmodule

/* File: tb/hssi_top_chk.sv */
// Purpose: Port-level assertions for hssi_top.
// Assumes: Bound to hssi_top; one clock domain.
// Notes:   Pin paths allow two sync flops plus one output flop.
`timescale 1ns/1ns
module hssi_top_chk
  import hssi_pkg::*;
#(
  parameter logic [6:0] P_I2C_DEF_ADDR = 7'h60
)
(
  input wire logic          i_clk,
  input wire logic          i_reset,
  input wire hssi_mode_type i_mode,
  input wire logic          i_spi_sclk,
  input wire logic          i_spi_ssel_n,
  input wire logic          o_spi_miso,
  input wire logic          o_spi_miso_oe,
  input wire logic          o_spi_rx_valid,
  input wire logic          o_spi_cmd_valid,
  input wire logic [6:0]    i_i2c_addr,
  input wire logic          i_i2c_addr_wr,
  input wire logic [6:0]    o_i2c_addr,
  input wire logic          o_i2c_scl_oe,
  input wire logic          o_i2c_sda_oe,
  input wire logic          i_i2c_hold,
  input wire logic          o_i2c_addr_hit
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  wire logic spi_off = (i_mode == HSSI_MODE_TB_I2C) || (i_mode == HSSI_MODE_OFF);
  wire logic i2c_off = (i_mode != HSSI_MODE_TB_I2C);

  spi_gated_a: assert property (spi_off[*3] |=> !o_spi_miso_oe && !o_spi_rx_valid)
    else $error("spi port active outside its modes");
  i2c_gated_a: assert property (i2c_off[*3] |=> !o_i2c_sda_oe && !o_i2c_scl_oe)
    else $error("i2c port drives outside its mode");
  one_port_a: assert property (!(o_spi_miso_oe && (o_i2c_sda_oe || o_i2c_scl_oe)))
    else $error("both host ports drive at once");
  cmd_gate_a: assert property ((o_spi_rx_valid || o_spi_cmd_valid) |->
    o_spi_rx_valid && (o_spi_cmd_valid == ($past(i_mode) == HSSI_MODE_STREAM)))
    else $error("command strobe in wrong mode");
  desel_float_a: assert property (i_spi_ssel_n[*4] |=> !o_spi_miso_oe)
    else $error("miso driven while deselected");
  miso_fall_a: assert property (o_spi_miso_oe && $past(o_spi_miso_oe) &&
    (o_spi_miso != $past(o_spi_miso)) |-> !$past(i_spi_sclk))
    else $error("miso changed while sclk high");
  addr_default_a: assert property ($past(i_reset) |-> o_i2c_addr == P_I2C_DEF_ADDR)
    else $error("i2c address not default after reset");
  addr_load_a: assert property (i_i2c_addr_wr |=> o_i2c_addr == $past(i_i2c_addr))
    else $error("i2c address not loaded");
  ack_own_a: assert property (o_i2c_addr_hit |-> o_i2c_sda_oe)
    else $error("address hit without ack");
  stretch_hold_a: assert property (o_i2c_scl_oe |-> $past(i_i2c_hold))
    else $error("scl stretched without hold");
endmodule

bind hssi_top hssi_top_chk #(.P_I2C_DEF_ADDR(P_I2C_DEF_ADDR)) u_chk (
  .i_clk, .i_reset, .i_mode, .i_spi_sclk, .i_spi_ssel_n, .o_spi_miso,
  .o_spi_miso_oe, .o_spi_rx_valid, .o_spi_cmd_valid, .i_i2c_addr, .i_i2c_addr_wr,
  .o_i2c_addr, .o_i2c_scl_oe, .o_i2c_sda_oe, .i_i2c_hold, .o_i2c_addr_hit
);

/* File: tb/hssi_host_model.sv */
// Purpose: Host master model for the SPI and I2C pins of hssi_top.
// Assumes: Pins change only just after i_clk rises.
// Notes:   SCL and SDA are open drain; an enable high pulls the line low.
`timescale 1ns/1ns
module hssi_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sclk,
  output logic      o_ssel_n,
  output logic      o_mosi,
  output logic      o_scl_oe,
  output logic      o_sda_oe,
  output logic      o_stuck
);
  // 160 ns SPI clock; an I2C bit of 4*63+1 cycles keeps under 400 kbit/s
  localparam int P_HALF = 8;
  localparam int P_QTR  = 63;
  initial begin
    o_sclk   = 1'b0;
    o_ssel_n = 1'b1;
    o_mosi   = 1'b0;
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_stuck  = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Lets the bench park the clock high to provoke a mode error
  task automatic sclk_set(input logic v);
    o_sclk <= v;
  endtask
  task automatic spi(input logic [15:0] d, input int n, output logic [15:0] r);
    r = '0;
    o_ssel_n <= 1'b0;
    w(P_HALF);
    for (int i = 0; i < n; i++) begin
      o_mosi <= d[i];
      w(P_HALF);
      o_sclk <= 1'b1;
      r[i] = i_miso;
      w(P_HALF);
      o_sclk <= 1'b0;
    end
    w(P_HALF);
    o_ssel_n <= 1'b1;
    o_mosi   <= ~o_mosi; // Undriven line must not keep showing the last bit
    w(P_HALF);
  endtask
  task automatic bit_x(input logic b, output logic r);
    int k;
    o_sda_oe <= ~b;
    w(P_QTR);
    o_scl_oe <= 1'b0;
    k = 0;
    w(1);
    while (i_scl !== 1'b1 && k < 5000) begin
      w(1);
      k++;
    end
    o_stuck <= (k == 5000);
    w(P_QTR);
    r = i_sda;
    w(P_QTR);
    o_scl_oe <= 1'b1;
    w(P_QTR);
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, ak);
  endtask
  task automatic i2c(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r,
                     output logic [1:0] ak);
    o_sda_oe <= 1'b1;
    w(P_QTR);
    o_scl_oe <= 1'b1;
    w(P_QTR);
    xb(a, r, ak[1]);
    xb(a[0] ? 8'hFF : d, r, ak[0]);
    o_sda_oe <= 1'b1;
    w(P_QTR);
    o_scl_oe <= 1'b0;
    w(P_QTR);
    o_sda_oe <= 1'b0;
    w(P_QTR);
  endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for hssi_top.
// Assumes: hssi_host_model plays the host on both links.
// Notes:   SPI rows per mode first, then framing, I2C and reset cases.
`timescale 1ns/1ns
module testbench
  import hssi_pkg::*;
;
  typedef struct packed {
    hssi_mode_type m;
    logic [15:0]   d;
    logic [1:0]    nv;
    logic [1:0]    nc;
  } hssi_row_type;
  localparam hssi_row_type P_ROWS [4] = '{
    '{HSSI_MODE_STREAM, 16'h5AA5, 2'h2, 2'h2},
    '{HSSI_MODE_TB_SPI, 16'hC33C, 2'h2, 2'h0},
    '{HSSI_MODE_TB_I2C, 16'h0FF0, 2'h0, 2'h0},
    '{HSSI_MODE_OFF,    16'h9669, 2'h0, 2'h0}};
  logic          i_clk = 1'b0;
  logic          i_reset = 1'b1;
  hssi_mode_type mode = HSSI_MODE_OFF;
  logic [7:0]    spi_tx = 8'h5A;
  logic [7:0]    i2c_tx = 8'hC3;
  logic [6:0]    i2c_addr = 7'h00;
  logic          addr_wr = 1'b0;
  logic          hold = 1'b0;
  logic [7:0]    rxd;
  logic [7:0]    i2d;
  int            fail_count = 0, tests_run = 0, nrx = 0, ncmd = 0, nfe = 0, nhit = 0, nstr = 0;
  int            nact = 0, nme = 0, nreq = 0;
  wire logic     sclk, ssel_n, mosi, miso, miso_oe, tx_load, rxv, cmdv, fe, i2v, hit, rd;
  wire logic     act, me, treq;
  wire logic     h_scl_oe, h_sda_oe, d_scl_oe, d_sda_oe, stuck;
  wire logic [7:0] rx_d, i2c_rx_d;
  wire logic [6:0] addr_q;
  wire logic     scl = ~(d_scl_oe | h_scl_oe);
  wire logic     sda = ~(d_sda_oe | h_sda_oe);
  wire logic     miso_w = miso_oe ? miso : 1'bz;

  hssi_top DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_mode(mode), .i_spi_sclk(sclk),
    .i_spi_ssel_n(ssel_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .i_spi_tx_data(spi_tx), .o_spi_tx_load(tx_load), .o_spi_rx_data(rx_d),
    .o_spi_rx_valid(rxv), .o_spi_cmd_valid(cmdv), .o_spi_active(act), .o_spi_frame_err(fe),
    .o_spi_mode_err(me), .i_i2c_addr(i2c_addr), .i_i2c_addr_wr(addr_wr), .o_i2c_addr(addr_q),
    .i_i2c_scl(scl), .i_i2c_sda(sda), .o_i2c_scl_oe(d_scl_oe), .o_i2c_sda_oe(d_sda_oe),
    .i_i2c_hold(hold), .i_i2c_tx_data(i2c_tx), .o_i2c_tx_req(treq), .o_i2c_rx_data(i2c_rx_d),
    .o_i2c_rx_valid(i2v), .o_i2c_addr_hit(hit), .o_i2c_read(rd)
  );
  hssi_host_model host (
    .i_clk(i_clk), .i_miso(miso_w), .i_scl(scl), .i_sda(sda), .o_sclk(sclk),
    .o_ssel_n(ssel_n), .o_mosi(mosi), .o_scl_oe(h_scl_oe), .o_sda_oe(h_sda_oe), .o_stuck(stuck)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Cleared on the falling edge so the counting process cannot lose it
  task automatic clr();
    @(negedge i_clk);
    nrx = 0;
    ncmd = 0;
    nfe = 0;
    nhit = 0;
    nstr = 0;
    nact = 0;
    nme = 0;
    nreq = 0;
    @(posedge i_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    nrx += (rxv === 1'b1);
    ncmd += (cmdv === 1'b1);
    nfe += (fe === 1'b1);
    nhit += (hit === 1'b1);
    nstr += (d_scl_oe === 1'b1);
    nact += (act === 1'b1);
    nme += (me === 1'b1);
    nreq += (treq === 1'b1);
    if (rxv === 1'b1) begin
      rxd = rx_d;
    end
    if (i2v === 1'b1) begin
      i2d = i2c_rx_d;
    end
    if (tx_load === 1'b1) begin
      spi_tx <= spi_tx + 8'h3C;
    end
    if (stuck === 1'b1) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    logic [15:0] r;
    logic [7:0]  b;
    logic [7:0]  e;
    logic [1:0]  ak;
    w(3);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      mode <= P_ROWS[i].m;
      w(4);
      clr();
      e = spi_tx;
      host.spi(P_ROWS[i].d, 16, r);
      w(8);
      chk("spi_rx_count", 16'(P_ROWS[i].nv), 16'(nrx));
      chk("spi_cmd_count", 16'(P_ROWS[i].nc), 16'(ncmd));
      chk("spi_active", 16'(P_ROWS[i].nv != 2'h0), 16'(nact > 0));
      if (P_ROWS[i].nv != 2'h0) begin
        chk("spi_rx_data", 16'(P_ROWS[i].d[15:8]), 16'(rxd));
        chk("spi_miso", {e + 8'h3C, e}, r);
      end
    end
    mode <= HSSI_MODE_STREAM;
    clr();
    host.spi(16'h0015, 5, r);
    w(8);
    chk("frame_err", 16'h1, 16'(nfe));
    chk("partial_rx", 16'h0, 16'(nrx));
    e = spi_tx;
    host.spi(16'h00E7, 8, r);
    w(8);
    chk("resync_rx", 16'h00E7, 16'(rxd));
    chk("resync_miso", 16'(e), r);
    // Clock already high at select breaks mode 0; no bit may be counted
    clr();
    host.sclk_set(1'b1);
    w(4);
    host.spi(16'h0000, 0, r);
    host.sclk_set(1'b0);
    w(8);
    chk("mode_err", 16'h1, 16'(nme));
    chk("mode_err_bits", 16'h0, 16'(nrx + nfe));
    host.i2c({7'h60, 1'b0}, 8'h11, b, ak);
    chk("i2c_off_ack", 16'h3, 16'(ak));
    mode <= HSSI_MODE_TB_I2C;
    hold <= 1'b1;
    w(4);
    clr();
    fork
      begin
        w(3500);
        hold <= 1'b0;
      end
    join_none
    host.i2c({7'h60, 1'b0}, 8'hA5, b, ak);
    chk("i2c_wr_ack", 16'h0, 16'(ak));
    chk("i2c_rx", 16'hA5, 16'(i2d));
    chk("i2c_hit", 16'h1, 16'(nhit));
    chk("i2c_stretch", 16'h1, 16'(nstr > 900));
    clr();
    host.i2c({7'h61, 1'b0}, 8'h5A, b, ak);
    chk("i2c_nack", 16'h3, 16'(ak));
    chk("i2c_nohit", 16'h0, 16'(nhit));
    i2c_addr <= 7'h2B;
    addr_wr <= 1'b1;
    w(1);
    addr_wr <= 1'b0;
    w(1);
    chk("i2c_addr", 16'h2B, 16'(addr_q));
    host.i2c({7'h2B, 1'b1}, 8'h00, b, ak);
    chk("i2c_rd_ack", 16'h1, 16'(ak));
    chk("i2c_rd_data", 16'hC3, 16'(b));
    chk("i2c_rd_flag", 16'h1, 16'(rd));
    chk("i2c_tx_req", 16'h1, 16'(nreq));
    i_reset <= 1'b1;
    w(3);
    i_reset <= 1'b0;
    w(1);
    chk("addr_after_reset", 16'h60, 16'(addr_q));
    print_verdict();
  end
endmodule
